/* rtl/srap_pkg.sv */
// Shared constants for the serial register access port: frame layout,
// response formats, register map, defaults and host-side timing.
// Assumes both ends import this package whole.
package srap_pkg;

  // Command and response frame layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 9;
  localparam int PAR_BIT = 8;
  localparam int DATA_HI = 7;
  localparam logic [3:0] LAST_BIT_IDX = 4'hf;
  localparam logic [15:0] POR_FRAME = 16'h8000;
  localparam logic [3:0] RD_FIXED = 4'hc;

  // Register map
  localparam logic [5:0] ADDR_EN = 6'h00;
  localparam logic [5:0] ADDR_CFG1 = 6'h01;
  localparam logic [5:0] ADDR_IADJ1 = 6'h07;
  localparam logic [5:0] ADDR_IADJ2 = 6'h08;
  localparam logic [5:0] ADDR_FAULT_STATUS_FIRST = 6'h11;
  localparam logic [5:0] ADDR_FAULT_STATUS_SECOND = 6'h12;
  localparam logic [5:0] ADDR_ALT_CFG = 6'h17;
  localparam logic [5:0] ADDR_ALT_IADJ1 = 6'h18;
  localparam logic [5:0] ADDR_ALT_IADJ2 = 6'h19;
  localparam logic [5:0] ADDR_LAST = 6'h24;
  localparam int FALLBACK_BIT = 4;
  localparam int FPIN_CLR_BIT = 7;
  localparam int FAULT_STATUS_FIRST_RTO_BIT = 7;
  localparam int FAULT_STATUS_FIRST_PC_BIT = 5;
  localparam int FAULT_STATUS_FIRST_TW_BIT = 4;
  localparam logic [7:0] PC_MASK = 8'h20;
  localparam logic [7:0] FAULT_STATUS_FIRST_EVT_MASK = 8'h9f;
  localparam logic [7:0] FAULT_STATUS_FIRST_RESET = 8'h20;

  // Power-on default of each register
  function automatic logic [7:0] reg_default(input logic [5:0] addr);
    case (addr)
      6'h00, 6'h13, 6'h17, 6'h21: reg_default = 8'h3c;
      6'h04: reg_default = 8'h55;
      6'h05: reg_default = 8'h05;
      6'h06: reg_default = 8'h77;
      6'h09: reg_default = 8'h01;
      6'h0e, 6'h14, 6'h1e: reg_default = 8'h0f;
      6'h0f, 6'h1f: reg_default = 8'h0a;
      6'h10, 6'h20: reg_default = 8'h99;
      6'h16: reg_default = 8'h22;
      default: reg_default = 8'h00;
    endcase
  endfunction

  // Frame check bit: XNOR over direction, address and data (odd parity)
  function automatic logic frame_check(input logic dir, input logic [5:0] addr,
                                       input logic [7:0] data);
    frame_check = ~^{dir, addr, data};
  endfunction

  // Host serial clock: half period in ns and in system clocks (5 ns)
  localparam int CLK_NS = 5;
  localparam int SCK_HALF_NS = 50;
  localparam logic [7:0] SCK_HALF_CYC = 8'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);

  // Host Wishbone map and fields
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam logic [7:0] HOST_RESP_OFS = 8'h08;
  localparam int HCMD_ADDR_LO = 8;
  localparam int HCMD_DIR_BIT = 16;
  localparam int HCMD_GO_BIT = 24;

endpackage

/* rtl/srap_link_if.sv */
// Four-wire serial link between host and device.
// The open-drain data return is pulled high when nobody drives it.
`timescale 1ns/1ps
`default_nettype none
interface srap_link_if;
  logic ssn_n;     // Select, active low
  logic sck;       // Serial clock, made by the host
  logic mosi;      // Host to device data
  logic miso_drv;  // Device drive level
  logic miso_oe;   // Device drives the return line
  wire logic miso; // Resolved return line

  // Pull-up resolves the open-drain line
  assign miso = miso_oe ? miso_drv : 1'b1;

  modport device (input ssn_n, input sck, input mosi, output miso_drv, output miso_oe);
  modport host (output ssn_n, output sck, output mosi, input miso);
endinterface
`default_nettype wire

/* rtl/srap_dev.sv */
// Device end of the serial register access port: shift engine, command
// decode, response framing and the 8-bit register array it serves.
// Assumes link pins are asynchronous to clk_i and are synchronised here;
// fault event inputs come from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
module srap_dev
  import srap_pkg::*;
(
  input wire logic clk_i,              // System clock, 200 MHz
  input wire logic rst_i,              // Power-on reset, synchronous, high
  srap_link_if.device link,            // Serial link pins
  input wire logic [7:0] fault_status_first_evt_i,   // Fault events for the first status register
  input wire logic [7:0] fault_status_second_evt_i,   // Fault events for the second status register
  input wire logic fallback_pin_i,     // Fallback mode pin, asynchronous
  output logic [1:0] ch_en_o,          // Active channel enables
  output logic [7:0] ch1_iadj_o,       // Active channel 1 current setting
  output logic [7:0] ch2_iadj_o,       // Active channel 2 current setting
  output logic fallback_mode_o,        // Fallback mode in force
  output logic fault_pin_clear_o       // Fault pin clear control bit
);

  // Synchronisers: only the second stage and later are read by logic
  logic ssn_s1_r, ssn_s2_r, ssn_s3_r;
  logic sck_s1_r, sck_s2_r, sck_s3_r;
  logic mosi_s1_r, mosi_s2_r;
  logic fb_s1_r, fb_s2_r;

  // Shift engine state
  logic [15:0] rx_r;
  logic [15:0] tx_r;
  logic [3:0] rise_cnt_r;
  logic full_r;
  logic [15:0] resp_r;
  logic oe_r;

  // Register file
  logic [7:0] regs_r [0:63];
  logic [7:0] fault_status_first_r;
  logic [7:0] fault_status_second_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ssn_s1_r <= 1'b1;
      ssn_s2_r <= 1'b1;
      ssn_s3_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
      fb_s1_r <= 1'b0;
      fb_s2_r <= 1'b0;
    end else begin
      ssn_s1_r <= link.ssn_n;
      ssn_s2_r <= ssn_s1_r;
      ssn_s3_r <= ssn_s2_r;
      sck_s1_r <= link.sck;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      mosi_s1_r <= link.mosi;
      mosi_s2_r <= mosi_s1_r;
      fb_s1_r <= fallback_pin_i;
      fb_s2_r <= fb_s1_r;
    end
  end

  // Edge detection on synchronised pins
  wire logic active = ~ssn_s2_r;
  wire logic sel_fall = ~ssn_s2_r & ssn_s3_r;
  wire logic sel_rise = ssn_s2_r & ~ssn_s3_r;
  wire logic sck_rise = active & sck_s2_r & ~sck_s3_r;
  wire logic sck_fall = active & ~sck_s2_r & sck_s3_r;

  // Received word fields, always the most recent sixteen bits
  wire logic f_dir = rx_r[CMD_BIT];
  wire logic [5:0] f_addr = rx_r[ADDR_HI:ADDR_LO];
  wire logic f_chk = rx_r[PAR_BIT];
  wire logic [7:0] f_data = rx_r[DATA_HI:0];

  // Frame checks, evaluated at select rising
  wire logic len_ok = full_r & (rise_cnt_r == 4'h0);
  wire logic chk_ok = f_chk == frame_check(f_dir, f_addr, f_data);
  wire logic rd_nz = ~f_dir & (|f_data);
  wire logic f_err = ~len_ok | ~chk_ok | rd_nz;
  wire logic clean = sel_rise & ~f_err;

  // Actions on a frame; an erroneous write is dropped here
  wire logic writable = (f_addr <= ADDR_LAST) & (f_addr != ADDR_FAULT_STATUS_FIRST) & (f_addr != ADDR_FAULT_STATUS_SECOND);
  wire logic do_wr = clean & f_dir & writable;
  wire logic clr1 = clean & ~f_dir & (f_addr == ADDR_FAULT_STATUS_FIRST);
  wire logic clr2 = clean & ~f_dir & (f_addr == ADDR_FAULT_STATUS_SECOND);
  wire logic wr_cfg1 = do_wr & (f_addr == ADDR_CFG1);

  // Read data: status registers are live, unlisted addresses stay zero
  wire logic [7:0] rd_val = (f_addr == ADDR_FAULT_STATUS_FIRST) ? fault_status_first_r :
                            (f_addr == ADDR_FAULT_STATUS_SECOND) ? fault_status_second_r : regs_r[f_addr];

  // Next response word, chosen by the command just received
  wire logic [15:0] rd_resp = {f_err, RD_FIXED, fault_status_first_r[FAULT_STATUS_FIRST_RTO_BIT], fault_status_first_r[FAULT_STATUS_FIRST_PC_BIT],
                               fault_status_first_r[FAULT_STATUS_FIRST_TW_BIT], rd_val};
  wire logic [15:0] wr_resp = {1'b0, f_dir, f_addr, f_data};
  wire logic [15:0] resp_nxt = ~f_dir ? rd_resp : (f_err ? POR_FRAME : wr_resp);

  // Outbound shifter: loads at select fall, moves on falling clock; received
  // bits follow behind so that a chained device sees them sixteen clocks later
  wire logic [15:0] tx_nxt = sel_fall ? resp_r :
                             sck_fall ? {tx_r[14:0], rx_r[0]} : tx_r;

  // Fault register next values; a new event wins over a clearing read
  wire logic [7:0] fault_status_first_keep = clr1 ? 8'h00 : (clr2 ? ~PC_MASK : 8'hff);
  wire logic [7:0] fault_status_first_nxt = (fault_status_first_r & fault_status_first_keep) | (fault_status_first_evt_i & FAULT_STATUS_FIRST_EVT_MASK);
  wire logic [7:0] fault_status_second_nxt = (fault_status_second_r & {8{~clr2}}) | fault_status_second_evt_i;

  // Fallback bit: pin sets it, a written zero clears it only with pin low
  wire logic fb_keep = regs_r[ADDR_CFG1][FALLBACK_BIT] & ~(wr_cfg1 & ~f_data[FALLBACK_BIT]);
  wire logic fb_nxt = fb_s2_r | fb_keep;
  wire logic fb_now = regs_r[ADDR_CFG1][FALLBACK_BIT];

  // Input capture on rising clock, first bit on top after sixteen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_r <= 16'h0000;
    end else if (sck_rise) begin
      rx_r <= {rx_r[14:0], mosi_s2_r};
    end
  end

  // Rising edge count: modulo sixteen plus a flag once sixteen were seen
  always_ff @(posedge clk_i) begin
    if (rst_i || sel_fall) begin
      rise_cnt_r <= 4'h0;
      full_r <= 1'b0;
    end else if (sck_rise) begin
      rise_cnt_r <= rise_cnt_r + 4'h1;
      if (rise_cnt_r == LAST_BIT_IDX) begin
        full_r <= 1'b1;
      end
    end
  end

  // Outbound word and open-drain enable; low bits pull the line, high bits
  // release it, so the enable follows the inverted top bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_r <= 16'h0000;
      oe_r <= 1'b0;
    end else begin
      tx_r <= tx_nxt;
      oe_r <= ~ssn_s2_r & ~tx_nxt[15];
    end
  end

  assign link.miso_drv = 1'b0;
  assign link.miso_oe = oe_r;

  // Response for the next frame; the first frame after reset is fixed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp_r <= POR_FRAME;
    end else if (sel_rise) begin
      resp_r <= resp_nxt;
    end
  end

  // Register array; unlisted entries are never written and read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 64; i++) begin
        regs_r[i] <= reg_default(6'(i));
      end
    end else begin
      if (do_wr) begin
        regs_r[f_addr] <= f_data;
      end
      regs_r[ADDR_CFG1][FALLBACK_BIT] <= fb_nxt;
    end
  end

  // Latched fault status; the power-cycled flag is raised by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_status_first_r <= FAULT_STATUS_FIRST_RESET;
      fault_status_second_r <= 8'h00;
    end else begin
      fault_status_first_r <= fault_status_first_nxt;
      fault_status_second_r <= fault_status_second_nxt;
    end
  end

  // Operating outputs follow the normal or the alternate register set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_en_o <= 2'b00;
      ch1_iadj_o <= 8'h00;
      ch2_iadj_o <= 8'h00;
      fallback_mode_o <= 1'b0;
      fault_pin_clear_o <= 1'b0;
    end else begin
      ch_en_o <= fb_now ? regs_r[ADDR_ALT_CFG][1:0] : regs_r[ADDR_EN][1:0];
      ch1_iadj_o <= fb_now ? regs_r[ADDR_ALT_IADJ1] : regs_r[ADDR_IADJ1];
      ch2_iadj_o <= fb_now ? regs_r[ADDR_ALT_IADJ2] : regs_r[ADDR_IADJ2];
      fallback_mode_o <= fb_now;
      fault_pin_clear_o <= regs_r[ADDR_EN][FPIN_CLR_BIT];
    end
  end

endmodule
`default_nettype wire

/* rtl/srap_host.sv */
// Host end of the serial register access port: a Wishbone classic slave
// that builds one 16-clock command frame per order and keeps the answer.
// Assumes the return line is asynchronous and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module srap_host
  import srap_pkg::*;
(
  input wire logic clk_i,              // System clock, 200 MHz
  input wire logic rst_i,              // Reset, synchronous, high
  input wire logic wb_cyc_i,           // Bus cycle
  input wire logic wb_stb_i,           // Bus strobe
  input wire logic wb_we_i,            // Bus write
  input wire logic [7:0] wb_adr_i,     // Byte address
  input wire logic [3:0] wb_sel_i,     // Byte lanes
  input wire logic [31:0] wb_dat_i,    // Write data
  output logic [31:0] wb_dat_o,        // Read data
  output logic wb_ack_o,               // Acknowledge
  srap_link_if.host link               // Serial link pins
);

  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_TRAIL, ST_GAP} srap_host_st_t;

  srap_host_st_t state_r;
  logic [7:0] tmr_r;
  logic [3:0] bit_r;
  logic [15:0] tx_r;
  logic [15:0] rx_r;
  logic [15:0] resp_r;
  logic [16:0] cmd_r;
  logic ssn_r, sck_r, mosi_r;
  logic miso_s1_r, miso_s2_r;

  // Bus decode; a request is served once, ack lasts one cycle
  wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr = req & wb_we_i;
  wire logic hit_cmd = wb_adr_i == HOST_CMD_OFS;
  wire logic hit_stat = wb_adr_i == HOST_STAT_OFS;
  wire logic hit_resp = wb_adr_i == HOST_RESP_OFS;
  wire logic busy = state_r != ST_IDLE;

  // Staged command with written lanes merged in
  wire logic [7:0] m_data = (wr & hit_cmd & wb_sel_i[0]) ? wb_dat_i[7:0] : cmd_r[7:0];
  wire logic [5:0] m_addr = (wr & hit_cmd & wb_sel_i[1]) ? wb_dat_i[13:8] : cmd_r[13:8];
  wire logic m_dir = (wr & hit_cmd & wb_sel_i[2]) ? wb_dat_i[HCMD_DIR_BIT] : cmd_r[HCMD_DIR_BIT];
  wire logic go = wr & hit_cmd & wb_sel_i[3] & wb_dat_i[HCMD_GO_BIT] & ~busy;

  // Frame word; reads always carry zero data
  wire logic [7:0] f_data = m_dir ? m_data : 8'h00;
  wire logic [15:0] frame = {m_dir, m_addr, frame_check(m_dir, m_addr, f_data), f_data};

  wire logic half_done = tmr_r == (SCK_HALF_CYC - 8'h01);
  wire logic [31:0] rd_word = hit_cmd ? {15'h0000, cmd_r} :
                              hit_stat ? {31'h00000000, busy} :
                              hit_resp ? {16'h0000, resp_r} : 32'h00000000;

  // Bus slave registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      cmd_r <= 17'h00000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req & ~wb_we_i) ? rd_word : 32'h00000000;
      if (wr & hit_cmd) begin
        cmd_r <= {m_dir, m_addr, 2'b00, m_data};
      end
    end
  end

  // Return line synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miso_s1_r <= 1'b1;
      miso_s2_r <= 1'b1;
    end else begin
      miso_s1_r <= link.miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  // Half-period timer, restarted at every phase change
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy || half_done) begin
      tmr_r <= 8'h00;
    end else begin
      tmr_r <= tmr_r + 8'h01;
    end
  end

  // Frame sequencer: select low, sixteen whole clocks, select high, gap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      ssn_r <= 1'b1;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      bit_r <= 4'h0;
      tx_r <= 16'h0000;
      rx_r <= 16'h0000;
      resp_r <= 16'h0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (go) begin
            ssn_r <= 1'b0;
            tx_r <= frame;
            mosi_r <= frame[15];
            bit_r <= 4'h0;
            state_r <= ST_LEAD;
          end
        end
        ST_LEAD, ST_LOW: begin
          if (half_done) begin
            sck_r <= 1'b1;
            state_r <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (half_done) begin
            sck_r <= 1'b0;
            rx_r <= {rx_r[14:0], miso_s2_r};
            tx_r <= {tx_r[14:0], 1'b0};
            mosi_r <= tx_r[14];
            bit_r <= bit_r + 4'h1;
            state_r <= (bit_r == LAST_BIT_IDX) ? ST_TRAIL : ST_LOW;
          end
        end
        ST_TRAIL: begin
          if (half_done) begin
            ssn_r <= 1'b1;
            resp_r <= rx_r;
            state_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (half_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign link.ssn_n = ssn_r;
  assign link.sck = sck_r;
  assign link.mosi = mosi_r;

endmodule
`default_nettype wire

/* testbench/srap_link_properties.sv */
// Checker for the serial link that joins the host end to the device end.
// Assumes every link signal is sampled on clk_i and reset is synchronous.
`timescale 1ns/1ps
`default_nettype none
module srap_link_properties (
  input wire logic clk_i,    // System clock
  input wire logic rst_i,    // Synchronous reset, high
  input wire logic ssn_n,    // Select, active low
  input wire logic sck,      // Serial clock
  input wire logic mosi,     // Host data
  input wire logic miso_drv, // Device drive level
  input wire logic miso_oe,  // Device drive enable
  input wire logic miso      // Resolved return line
);
  logic sck_d_r;
  logic [5:0] rise_cnt_r;
  logic [5:0] rise_cnt_nxt;

  // Rising clock edges in the current frame; cleared while idle
  assign rise_cnt_nxt = ssn_n ? 6'h00 : (sck && !sck_d_r) ? rise_cnt_r + 6'h01 : rise_cnt_r;

  // Edge finder and counter, kept tiny so the checks stay cheap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_d_r <= 1'b0;
      rise_cnt_r <= 6'h00;
    end else begin
      sck_d_r <= sck;
      rise_cnt_r <= rise_cnt_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Frame shape produced by the host end
  frame_len_a: assert property ($rose(ssn_n) |-> rise_cnt_r == 6'h10)
    else $error("frame ended without exactly sixteen clocks");
  sck_idle_a: assert property (ssn_n |-> !sck)
    else $error("serial clock high while deselected");
  setup_gap_a: assert property ($fell(ssn_n) |-> !sck [*8] ##[1:4] sck)
    else $error("first clock rise not one half period after select");
  sck_high_a: assert property ($rose(sck) |-> sck [*8] ##[1:4] !sck)
    else $error("serial clock high phase has wrong length");
  end_gap_a: assert property ($rose(ssn_n) |-> ssn_n [*8])
    else $error("select reasserted too soon");
  mosi_hold_a: assert property (sck && sck_d_r |-> $stable(mosi))
    else $error("host data moved while clock high");
  // Device return line: open drain, stable while the host samples it
  miso_drain_a: assert property (miso_oe |-> !miso_drv)
    else $error("return line driven high");
  idle_float_a: assert property (ssn_n [*6] |-> !miso_oe && miso)
    else $error("return line not released while deselected");
  miso_hold_a: assert property (sck && !ssn_n |-> $stable(miso))
    else $error("return bit changed outside a falling clock");

  frame_done_c: cover property ($rose(ssn_n));
  drive_low_c: cover property ($rose(miso_oe));
  bit_change_c: cover property (!ssn_n && $fell(miso));
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Bench: host end and device end face each other; a second device end is
// driven directly by the bench to break the framing rules on purpose.
`timescale 1ns/1ps
`default_nettype none
module tb
  import srap_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, fb_pin = 1'b0, fb_mode, fpc, fb;
  logic [7:0] wb_adr = 8'h00, fault_status_first_evt = 8'h00, fault_status_second_evt = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r, rx;
  logic [1:0] ch_en;
  logic [7:0] ch1_iadj, ch2_iadj, iadj_b, pre_iadj, f1, f2;
  logic [7:0] m_reg [64];
  logic [15:0] exp_resp;
  logic [14:0] seq [6] = '{15'h0000, 15'h115a, 15'h1100, 15'h1200, 15'h1100, 15'h3f00};
  int mismatches = 0, samples_checked = 0, cycles = 0;
  logic dir;
  logic [5:0] a;
  logic [7:0] d;

  srap_link_if lnk();
  srap_link_if lnk2();

  srap_host i_srap_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .link(lnk.host));
  srap_dev i_srap_dev (.clk_i(clk_i), .rst_i(rst_i), .link(lnk.device), .fault_status_first_evt_i(fault_status_first_evt),
    .fault_status_second_evt_i(fault_status_second_evt), .fallback_pin_i(fb_pin), .ch_en_o(ch_en), .ch1_iadj_o(ch1_iadj),
    .ch2_iadj_o(ch2_iadj), .fallback_mode_o(fb_mode), .fault_pin_clear_o(fpc));
  // Second device: only the link misbehaves, so its side inputs are tied
  srap_dev i_srap_dev_b (.clk_i(clk_i), .rst_i(rst_i), .link(lnk2.device), .fault_status_first_evt_i(8'h00),
    .fault_status_second_evt_i(8'h00), .fallback_pin_i(1'b0), .ch_en_o(), .ch1_iadj_o(iadj_b),
    .ch2_iadj_o(), .fallback_mode_o(), .fault_pin_clear_o());
  srap_link_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .ssn_n(lnk.ssn_n), .sck(lnk.sck),
    .mosi(lnk.mosi), .miso_drv(lnk.miso_drv), .miso_oe(lnk.miso_oe), .miso(lnk.miso));

  // Clock and hang guard; the ceiling is about two and a half times the expected run
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      final_report();
    end
  end

  function automatic logic [15:0] cmd_word(input logic dr, input logic [5:0] ad,
                                           input logic [7:0] dt);
    return {dr, ad, ~^{dr, ad, dt}, dt};
  endfunction

  // Power-on values of the register map
  function automatic logic [7:0] dflt(input logic [5:0] ad);
    case (ad)
      6'h00, 6'h13, 6'h17, 6'h21: return 8'h3c;
      6'h04: return 8'h55;
      6'h05: return 8'h05;
      6'h06: return 8'h77;
      6'h09: return 8'h01;
      6'h0e, 6'h14, 6'h1e: return 8'h0f;
      6'h0f, 6'h1f: return 8'h0a;
      6'h10, 6'h20: return 8'h99;
      6'h16: return 8'h22;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] rd_val(input logic [5:0] ad);
    if (ad == 6'h01) return {m_reg[1][7:5], fb, m_reg[1][3:0]};
    if (ad == 6'h11) return f1;
    if (ad == 6'h12) return f2;
    if (ad > 6'h24) return 8'h00;
    return m_reg[ad];
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask

  // Classic single cycle; holds the request until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] dt,
                    output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= ad;
    wb_dat_w <= dt;
    wb_sel <= 4'hf;
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // One frame on the main link; checks the answer word to the previous one
  task automatic run(input logic dr, input logic [5:0] ad, input logic [7:0] dt);
    logic [31:0] q;
    wb(1'b1, HOST_CMD_OFS, {7'h00, 1'b1, 7'h00, dr, 2'h0, ad, dt}, q);
    q = 32'h1;
    while (q[0] !== 1'b0) wb(1'b0, HOST_STAT_OFS, 32'h0, q);
    wb(1'b0, HOST_RESP_OFS, 32'h0, q);
    chk("response", exp_resp, q[15:0]);
    // The host end zeroes read data, so no read on this link is refused
    if (dr) begin
      exp_resp = {2'b01, ad, dt};
      if (ad <= 6'h24 && ad != 6'h11 && ad != 6'h12) m_reg[ad] = dt;
      if (ad == 6'h01) fb = fb_pin | (fb & dt[4]);
    end else begin
      exp_resp = {1'b0, 4'hc, f1[7], f1[5], f1[4], rd_val(ad)};
      if (ad == 6'h11) f1 = 8'h00;
      if (ad == 6'h12) {f1[5], f2} = 9'h000;
    end
    repeat (4) @(posedge clk_i);
    chk("ch_en", {14'h0, fb ? m_reg[6'h17][1:0] : m_reg[0][1:0]}, {14'h0, ch_en});
    chk("ch1_iadj", {8'h0, fb ? m_reg[6'h18] : m_reg[7]}, {8'h0, ch1_iadj});
    chk("ch2_iadj", {8'h0, fb ? m_reg[6'h19] : m_reg[8]}, {8'h0, ch2_iadj});
    chk("fault_pin_clear", {15'h0, m_reg[0][7]}, {15'h0, fpc});
    chk("fallback_mode", {15'h0, fb}, {15'h0, fb_mode});
  endtask

  // Bench-made frame of n clocks on the second link, MSB of w[n-1:0] first
  task automatic bframe(input logic [31:0] w, input int n, output logic [31:0] r);
    r = 32'h0;
    lnk2.ssn_n <= 1'b0;
    lnk2.mosi <= n > 0 ? w[n-1] : 1'b0;
    repeat (10) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      lnk2.sck <= 1'b1;
      repeat (10) @(posedge clk_i);
      r = {r[30:0], lnk2.miso};
      lnk2.sck <= 1'b0;
      lnk2.mosi <= i < n - 1 ? w[n-2-i] : 1'b0;
      repeat (10) @(posedge clk_i);
    end
    pre_iadj = iadj_b;
    lnk2.ssn_n <= 1'b1;
    lnk2.mosi <= ~lnk2.mosi;
    repeat (12) @(posedge clk_i);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    lnk2.ssn_n = 1'b1;
    lnk2.sck = 1'b0;
    lnk2.mosi = 1'b0;
    for (int i = 0; i < 64; i++) m_reg[i] = dflt(6'(i));
    {f1, f2, fb, exp_resp} = {8'h20, 8'h00, 1'b0, 16'h8000};
    void'($urandom(10));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("reset_ch_en", 16'h0000, {14'h0, ch_en});
    fault_status_first_evt <= 8'h90;
    fault_status_second_evt <= 8'h41;
    @(posedge clk_i);
    {fault_status_first_evt, fault_status_second_evt} <= 16'h0000;
    {f1, f2} = {8'hb0, 8'h41};
    foreach (seq[i]) run(seq[i][14], seq[i][13:8], seq[i][7:0]);
    $display("test status reads done");
    for (int i = 0; i < 40; i++) begin
      dir = 1'($urandom);
      a = dir ? 6'($urandom % 37) : 6'($urandom);
      d = (dir || $urandom % 8 == 0) ? 8'($urandom) : 8'h00;
      run(dir, a, d);
    end
    $display("test random frames done");
    run(1'b1, 6'h18, 8'h11);
    run(1'b1, 6'h19, 8'h22);
    run(1'b1, 6'h17, 8'h02);
    fb_pin <= 1'b1;
    fb = 1'b1;
    repeat (10) @(posedge clk_i);
    run(1'b1, 6'h01, 8'h00);
    run(1'b0, 6'h01, 8'h00);
    fb_pin <= 1'b0;
    repeat (10) @(posedge clk_i);
    run(1'b1, 6'h01, 8'h10);
    run(1'b1, 6'h01, 8'h00);
    run(1'b0, 6'h07, 8'h00);
    $display("test fallback done");
    bframe({16'h0, cmd_word(1'b0, 6'h07, 8'h00)}, 16, rx);
    chk("first_answer", 16'h8000, rx[15:0]);
    bframe(32'h0, 0, rx);
    bframe({16'h0, cmd_word(1'b0, 6'h07, 8'h00)}, 16, rx);
    chk("no_clock_err", 16'h0001, {15'h0, rx[15]});
    bframe({16'h0, cmd_word(1'b1, 6'h07, 8'h5a)} >> 8, 8, rx);
    chk("short_answer", {8'h00, 1'b0, 4'hc, 3'b010}, {8'h00, rx[7:0]});
    bframe({16'h0, cmd_word(1'b1, 6'h08, 8'h3c) ^ 16'h0100}, 16, rx);
    chk("short_err", 16'h0001, {15'h0, rx[15]});
    bframe({cmd_word(1'b1, 6'h07, 8'h33), cmd_word(1'b1, 6'h07, 8'ha5)}, 32, rx);
    chk("parity_err", 16'h8000, rx[31:16]);
    chk("pass_through", cmd_word(1'b1, 6'h07, 8'h33), rx[15:0]);
    chk("write_early", 16'h0000, {8'h0, pre_iadj});
    chk("write_late", 16'h00a5, {8'h0, iadj_b});
    bframe({16'h0, cmd_word(1'b0, 6'h08, 8'h00)}, 16, rx);
    chk("write_echo", {2'b01, 6'h07, 8'ha5}, rx[15:0]);
    bframe({16'h0, cmd_word(1'b0, 6'h07, 8'h00)}, 16, rx);
    chk("bad_write_kept", {1'b0, 4'hc, 3'b010, 8'h00}, rx[15:0]);
    // Read with nonzero data: refused, so the latched status must survive it
    bframe({16'h0, cmd_word(1'b0, 6'h11, 8'h5a)}, 16, rx);
    chk("read_answer", {1'b0, 4'hc, 3'b010, 8'ha5}, rx[15:0]);
    bframe({16'h0, cmd_word(1'b0, 6'h11, 8'h00)}, 16, rx);
    chk("read_data_err", {1'b1, 4'hc, 3'b010, 8'h20}, rx[15:0]);
    bframe({16'h0, cmd_word(1'b0, 6'h11, 8'h00)}, 16, rx);
    chk("status_before_clear", {1'b0, 4'hc, 3'b010, 8'h20}, rx[15:0]);
    bframe({16'h0, cmd_word(1'b0, 6'h07, 8'h00)}, 16, rx);
    chk("status_cleared", {1'b0, 4'hc, 3'b000, 8'h00}, rx[15:0]);
    $display("test link errors done");
    final_report();
  end
endmodule
`default_nettype wire
